// ---- rtl/focr_pkg.sv ----
// package: register indices, reset values and field layouts of the floppy option block
package focr_pkg;

    // configuration index values of the registers held here
    localparam logic [7:0] IDX_LOCK = 8'h01;
    localparam logic [7:0] IDX_FLOPPY_OPT = 8'h03;
    localparam logic [7:0] IDX_EXT_SETUP = 8'h04;
    // highest index covered by the lock
    localparam logic [7:0] IDX_LAST_LOCKED = 8'h0f;

    // power-up values
    localparam logic [7:0] RST_FLOPPY_OPT = 8'h78;
    localparam logic [7:0] RST_EXT_SETUP = 8'h00;
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic RST_LOCK = 1'b1;

    // bit position of the lock bit inside its register
    localparam int LOCK_POS = 7;

    // floppy option register layout, msb first
    typedef struct packed {
        logic shared_pin_sel; // bit 7: shared pin function select
        logic iface_ident;    // bit 6: interface mode, upper bit
        logic encoding_mode_bit; // bit 5: interface mode, lower bit
        logic drive_opt_1;    // bit 4
        logic drive_opt_0;    // bit 3
        logic pin_sub_sel;    // bit 2: shared pin sub-select
        logic floppy_mode2;   // bit 1: enhanced floppy mode two
        logic reserved0;      // bit 0: reads as zero
    } focr_floppy_opt_t;

    // drive interface modes
    typedef enum logic [1:0] {
        FOCR_MODE_AT,
        FOCR_MODE_RESERVED,
        FOCR_MODE_LATER,
        FOCR_MODE_COMPACT
    } focr_iface_t;

    // one two-way pin as seen from the design
    typedef struct packed {
        logic o;  // value driven
        logic oe; // high while this end drives
    } focr_pin_drv_t;

endpackage

// ---- rtl/focr_rate_map.sv ----
// rate pin mapper: derives the two rate pins from the rate select bits
`timescale 1ns/1ps
`default_nettype none

module focr_rate_map (
    input wire logic [1:0] rate_select_bits,
    input wire logic drive_opt_0,
    input wire logic drive_opt_1,
    input wire logic floppy_mode2,
    output focr_pkg::focr_pin_drv_t rate_out_0,
    output focr_pkg::focr_pin_drv_t rate_out_1
);

    // effective options; mode two forces the direct mapping
    wire logic opt0_eff = drive_opt_0 & ~floppy_mode2; // RQ4
    wire logic opt1_eff = drive_opt_1 & ~floppy_mode2; // RQ4
    // both options set: pins turn into inputs
    wire logic pins_input = opt0_eff & opt1_eff; // RQ6
    // option 0 alone: upper pin is the xnor of both select bits
    wire logic use_xnor = opt0_eff & ~opt1_eff;
    wire logic xnor_bit = ~(rate_select_bits[1] ^ rate_select_bits[0]);

    // pure combinational path, no added latency
    assign rate_out_0.o = rate_select_bits[0]; // RQ5 RQ16
    assign rate_out_1.o = use_xnor ? xnor_bit : rate_select_bits[1]; // RQ5 RQ6 RQ16
    assign rate_out_0.oe = ~pins_input; // RQ6
    assign rate_out_1.oe = ~pins_input; // RQ6

endmodule

`default_nettype wire

// ---- rtl/focr_top.sv ----
// floppy option configuration block with index/data access and pin steering
// Functional notes
// [RQ1] bit 1 selects normal or enhanced mode two
// [RQ2] option bits 3,4 steer the rate pins
// [RQ3] both option bits power up as one
// [RQ4] mode two makes option bits don't care
// [RQ5] options zero: rate pins follow select bits
// [RQ6] option 0 alone: xnor; both: pins input
// [RQ7] bits 6,5 choose the drive interface mode
// [RQ8] bit 7 clear: drive-two input, parallel interrupt
// [RQ9] bit 7 set: decode or second interrupt, float
// [RQ10] game-port variant drops the drive-two input
// [RQ11] software uses index 04h in config mode
// [RQ12] extended setup register powers up as 00h
// [RQ13] power-up defaults, kept over hardware reset
// [RQ14] software uses index 03h; power-up value 78h
// [RQ15] cleared lock blocks indices 0-15 until reset
// [RQ16] rate pins combinational, no extra delay
// [RQ17] bit 0 reserved, always reads zero
`timescale 1ns/1ps
`default_nettype none

module focr_top #(
    parameter bit HAS_GAME_PORT = 1'b0 // variant with game-port select logic
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hw_reset,
    input wire logic cfg_mode,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic cfg_port_data,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic [1:0] rate_select_bits,
    input wire logic rate_out_0_i,
    output logic rate_out_0_o,
    output logic rate_out_0_oe,
    input wire logic rate_out_1_i,
    output logic rate_out_1_o,
    output logic rate_out_1_oe,
    input wire logic shared_a_i,
    output logic shared_a_o,
    output logic shared_a_oe,
    input wire logic shared_b_i,
    output logic shared_b_o,
    output logic shared_b_oe,
    input wire logic parallel_interrupt,
    input wire logic second_parallel_interrupt,
    input wire logic extra_address_decode,
    output logic drive_two_indicator,
    output logic enhanced_mode2,
    output focr_pkg::focr_iface_t iface_mode,
    output logic [7:0] ext_setup,
    output logic [1:0] rate_pins_in
);

    // stored state
    logic [7:0] index_r; // config index register
    logic [7:0] index_nxt;
    focr_pkg::focr_floppy_opt_t fopt_r; // floppy option register
    focr_pkg::focr_floppy_opt_t fopt_nxt;
    logic [7:0] ext_r; // extended setup register
    logic [7:0] ext_nxt;
    logic lock_r; // access enable, high = open
    logic lock_nxt;
    logic [7:0] rdata_r; // read data holder
    logic [7:0] rdata_nxt;

    // access decode
    wire logic wr_index = cfg_mode & cfg_wr & ~cfg_port_data;
    wire logic wr_data = cfg_mode & cfg_wr & cfg_port_data;
    wire logic rd_index = cfg_mode & cfg_rd & ~cfg_port_data;
    wire logic rd_data = cfg_mode & cfg_rd & cfg_port_data;
    // indices 0..15 are gated by the lock
    wire logic in_locked_range = (index_r <= focr_pkg::IDX_LAST_LOCKED);
    wire logic data_open = lock_r | ~in_locked_range; // RQ15
    wire logic wr_ok = wr_data & data_open; // RQ15
    wire logic sel_lock = (index_r == focr_pkg::IDX_LOCK);
    wire logic sel_fopt = (index_r == focr_pkg::IDX_FLOPPY_OPT); // RQ14
    wire logic sel_ext = (index_r == focr_pkg::IDX_EXT_SETUP); // RQ11

    // register read mux, bit 0 of the option register forced low
    wire logic [7:0] fopt_view = {fopt_r[7:1], 1'b0}; // RQ17
    wire logic [7:0] lock_view = {lock_r, 7'h00};
    wire logic [7:0] data_view;
    assign data_view = !data_open ? 8'h00 : // RQ15
        sel_lock ? lock_view :
        sel_fopt ? fopt_view :
        sel_ext ? ext_r :
        8'h00;

    // next values
    assign index_nxt = wr_index ? cfg_wdata : index_r;
    assign fopt_nxt = (wr_ok && sel_fopt) ? {cfg_wdata[7:1], 1'b0} : fopt_r; // RQ2 RQ17
    assign ext_nxt = (wr_ok && sel_ext) ? cfg_wdata : ext_r;
    // lock only ever clears by software; set back only by reset
    assign lock_nxt = (wr_ok && sel_lock) ? (lock_r & cfg_wdata[focr_pkg::LOCK_POS]) : lock_r;
    assign rdata_nxt = rd_index ? index_r : rd_data ? data_view : rdata_r;

    // config storage: only power-up reset loads defaults, hw_reset ignored
    always_ff @(posedge clk_sys) begin
        if (rst) begin // RQ13
            index_r <= focr_pkg::RST_INDEX;
            fopt_r <= focr_pkg::RST_FLOPPY_OPT; // RQ3 RQ14
            ext_r <= focr_pkg::RST_EXT_SETUP; // RQ12
            lock_r <= focr_pkg::RST_LOCK; // RQ15
            rdata_r <= 8'h00;
        end else begin
            index_r <= index_nxt;
            fopt_r <= fopt_nxt;
            ext_r <= ext_nxt;
            lock_r <= lock_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // rate pin steering
    focr_pkg::focr_pin_drv_t rate0_drv;
    focr_pkg::focr_pin_drv_t rate1_drv;
    focr_rate_map u_rate_map (
        .rate_select_bits(rate_select_bits),
        .drive_opt_0(fopt_r.drive_opt_0), // RQ2
        .drive_opt_1(fopt_r.drive_opt_1), // RQ2
        .floppy_mode2(fopt_r.floppy_mode2), // RQ4
        .rate_out_0(rate0_drv),
        .rate_out_1(rate1_drv)
    );
    assign rate_out_0_o = rate0_drv.o;
    assign rate_out_0_oe = rate0_drv.oe;
    assign rate_out_1_o = rate1_drv.o;
    assign rate_out_1_oe = rate1_drv.oe;
    // pin levels while they act as inputs
    assign rate_pins_in = {rate_out_1_i, rate_out_0_i};

    // mode outputs
    assign enhanced_mode2 = fopt_r.floppy_mode2; // RQ1
    wire logic [1:0] mode_bits = {fopt_r.iface_ident, fopt_r.encoding_mode_bit};
    assign iface_mode = (mode_bits == 2'b11) ? focr_pkg::FOCR_MODE_AT : // RQ7
        (mode_bits == 2'b10) ? focr_pkg::FOCR_MODE_RESERVED :
        (mode_bits == 2'b01) ? focr_pkg::FOCR_MODE_LATER :
        focr_pkg::FOCR_MODE_COMPACT;
    assign ext_setup = ext_r;
    assign cfg_rdata = rdata_r;

    // shared pin functions
    wire logic shared_on = fopt_r.shared_pin_sel;
    wire logic shared_sub = fopt_r.pin_sub_sel;
    // pin a: drive-two input, extra decode out, or second interrupt out
    assign shared_a_oe = shared_on; // RQ8 RQ9
    assign shared_a_o = !shared_on ? 1'b0 :
        shared_sub ? second_parallel_interrupt : extra_address_decode; // RQ9
    // drive-two input absent on the game-port variant
    assign drive_two_indicator = ~shared_on & shared_a_i & ~HAS_GAME_PORT; // RQ8 RQ10
    // pin b: parallel interrupt, floating in the last combination
    assign shared_b_oe = ~(shared_on & shared_sub); // RQ8 RQ9
    assign shared_b_o = parallel_interrupt & ~(shared_on & shared_sub); // RQ8
    wire logic unused_b = shared_b_i;

    // checks
    mode2_write_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ1
        (wr_ok && sel_fopt) |=> (enhanced_mode2 == $past(cfg_wdata[1])))
        else $error("mode two bit not taken from write");
    opt_powerup_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ3
        $past(rst) |-> (fopt_r.drive_opt_0 && fopt_r.drive_opt_1 && fopt_r == 8'h78))
        else $error("option bits not one after power-up");
    mode2_ignore_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ4
        fopt_r.floppy_mode2 |-> (rate_out_0_oe && rate_out_1_oe
        && {rate_out_1_o, rate_out_0_o} == rate_select_bits))
        else $error("option bits not ignored in mode two");
    rate_direct_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ5
        (!fopt_r.drive_opt_0 && !fopt_r.drive_opt_1)
        |-> ({rate_out_1_o, rate_out_0_o} == rate_select_bits && rate_out_0_oe))
        else $error("direct rate mapping wrong");
    rate_xnor_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ6
        (!fopt_r.floppy_mode2 && fopt_r.drive_opt_0 && !fopt_r.drive_opt_1)
        |-> (rate_out_1_o == (rate_select_bits[1] ~^ rate_select_bits[0])
        && rate_out_0_o == rate_select_bits[0]))
        else $error("xnor rate mapping wrong");
    rate_input_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ6
        (!fopt_r.floppy_mode2 && fopt_r.drive_opt_0 && fopt_r.drive_opt_1)
        |-> (!rate_out_0_oe && !rate_out_1_oe))
        else $error("rate pins still driven");
    rate_comb_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ16
        ($changed(rate_select_bits) && fopt_r.floppy_mode2)
        |-> (rate_out_0_o == rate_select_bits[0]))
        else $error("rate pin lags select bits");
    iface_mode_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ7
        (mode_bits != 2'b11 || iface_mode == focr_pkg::FOCR_MODE_AT)
        && (mode_bits != 2'b10 || iface_mode == focr_pkg::FOCR_MODE_RESERVED)
        && (mode_bits != 2'b01 || iface_mode == focr_pkg::FOCR_MODE_LATER)
        && (mode_bits != 2'b00 || iface_mode == focr_pkg::FOCR_MODE_COMPACT))
        else $error("interface mode decode wrong");
    shared_off_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ8
        !shared_on |-> (!shared_a_oe && shared_b_oe && shared_b_o == parallel_interrupt))
        else $error("shared pins wrong with bit 7 clear");
    shared_on_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ9
        shared_on |-> (shared_a_oe && (shared_sub ? (!shared_b_oe
        && shared_a_o == second_parallel_interrupt) : shared_a_o == extra_address_decode)))
        else $error("shared pins wrong with bit 7 set");
    game_var_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ10
        drive_two_indicator |-> (!HAS_GAME_PORT && !shared_on && shared_a_i))
        else $error("drive-two input present on game variant");
    ext_powerup_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ12
        $past(rst) |-> (ext_setup == 8'h00))
        else $error("extended setup not zero after power-up");
    hw_keep_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ13
        (hw_reset && !wr_ok) |=> ($stable(fopt_r) && $stable(ext_r)))
        else $error("hardware reset disturbed config");
    lock_block_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ15
        (!lock_r && in_locked_range) |=> ($stable(fopt_r) && $stable(ext_r) && !lock_r))
        else $error("locked register changed");
    rsvd_read_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ17
        (rd_data && sel_fopt) |=> (cfg_rdata[0] == 1'b0
        && cfg_rdata[7:1] == $past(fopt_r[7:1]) || !$past(lock_r)))
        else $error("reserved bit read non-zero");

endmodule

`default_nettype wire

// ---- tb/focr_far_side.sv ----
// far side model: drive and bus levels on the two rate pins and two shared pins
`timescale 1ns/1ps
`default_nettype none

module focr_far_side (
    input wire logic [3:0] pin_o,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] far_lvl,
    output logic [3:0] pin_i
);
    // order: rate 0, rate 1, shared a, shared b
    // a released pin shows the far side's level (drive, pull-up), never the stale value
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & far_lvl);
endmodule

`default_nettype wire

// ---- tb/floppy_option_config_register_tb_top.sv ----
// bench: index/data accesses, rate and shared pin steering of the option block
`timescale 1ns/1ps
`default_nettype none

module floppy_option_config_register_tb_top;
    logic clk_sys = 1'b0; // 250 mhz
    logic rst = 1'b1; // held 4 cycles
    logic hw_reset = 1'b0, cfg_mode = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, cfg_port_data = 1'b0;
    logic [7:0] cfg_wdata = 8'h00;
    logic [1:0] rate_select_bits = 2'h0;
    logic [3:0] far_lvl = 4'ha; // far side levels, shared b pulled up
    logic parallel_interrupt = 1'b0, second_parallel_interrupt = 1'b0, extra_address_decode = 1'b0;
    logic [7:0] cfg_rdata, ext_setup;
    logic [3:0] pin_o, pin_oe, pin_i;
    logic drive_two_indicator, enhanced_mode2;
    logic [1:0] rate_pins_in;
    focr_pkg::focr_iface_t iface_mode;
    int error_cnt = 0;
    int compares = 0;
    logic [7:0] v;

    // clock
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    focr_top dut (.clk_sys, .rst, .hw_reset, .cfg_mode, .cfg_wr, .cfg_rd, .cfg_port_data,
        .cfg_wdata, .cfg_rdata, .rate_select_bits, .rate_out_0_i(pin_i[0]),
        .rate_out_0_o(pin_o[0]), .rate_out_0_oe(pin_oe[0]), .rate_out_1_i(pin_i[1]),
        .rate_out_1_o(pin_o[1]), .rate_out_1_oe(pin_oe[1]), .shared_a_i(pin_i[2]),
        .shared_a_o(pin_o[2]), .shared_a_oe(pin_oe[2]), .shared_b_i(pin_i[3]),
        .shared_b_o(pin_o[3]), .shared_b_oe(pin_oe[3]), .parallel_interrupt,
        .second_parallel_interrupt, .extra_address_decode, .drive_two_indicator,
        .enhanced_mode2, .iface_mode, .ext_setup, .rate_pins_in);
    focr_far_side far (.pin_o, .pin_oe, .far_lvl, .pin_i);

    task automatic end_of_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one write strobe on the index or data port
    task automatic put(input logic port, input logic [7:0] d);
        @(negedge clk_sys);
        cfg_port_data = port;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        put(1'b0, idx);
        put(1'b1, d);
    endtask
    task automatic rreg(input logic [7:0] idx, input logic [7:0] e);
        put(1'b0, idx);
        @(negedge clk_sys);
        cfg_port_data = 1'b1;
        cfg_rd = 1'b1;
        @(negedge clk_sys);
        cfg_rd = 1'b0;
        @(negedge clk_sys);
        chk("cfg_rdata", e, cfg_rdata);
    endtask
    // rate pins against the option value in force
    task automatic chk_rate(input logic [7:0] o);
        logic [1:0] s;
        logic [1:0] e;
        logic drv;
        s = rate_select_bits;
        drv = o[1] || o[4:3] != 2'b11;
        e = (!o[1] && o[4:3] == 2'b01) ? {~(s[1] ^ s[0]), s[0]} : s;
        chk("rate_oe", {6'h0, drv, drv}, {6'h0, pin_oe[1:0]});
        if (drv) chk("rate_o", {6'h0, e}, {6'h0, pin_o[1:0]});
        else chk("rate_in", {6'h0, far_lvl[1:0]}, {6'h0, rate_pins_in});
    endtask

    // watchdog
    initial begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        cfg_mode = 1'b1;
        chk_rate(8'h78);
        chk("mode", 8'h00, {6'h0, iface_mode});
        rreg(focr_pkg::IDX_FLOPPY_OPT, 8'h78);
        rreg(focr_pkg::IDX_EXT_SETUP, 8'h00);
        // every option pair with and without mode two, every select code
        for (int i = 0; i < 8; i++) begin
            v = {3'b011, i[1:0], 1'b0, i[2], 1'b1};
            wreg(focr_pkg::IDX_FLOPPY_OPT, v);
            rreg(focr_pkg::IDX_FLOPPY_OPT, v & 8'hfe);
            chk("mode2", {7'h0, v[1]}, {7'h0, enhanced_mode2});
            for (int s = 0; s < 4; s++) begin
                rate_select_bits = s[1:0];
                @(negedge clk_sys);
                chk_rate(v);
            end
        end
        // interface mode codes
        for (int j = 0; j < 4; j++) begin
            wreg(focr_pkg::IDX_FLOPPY_OPT, {1'b0, j[1:0], 5'h0});
            @(negedge clk_sys);
            chk("iface", {6'h0, ~j[1:0]}, {6'h0, iface_mode});
        end
        // shared pin functions with two input patterns
        for (int k = 0; k < 6; k++) begin
            v = {k[2:1] != 2'b00, 4'h0, k[2], 2'h0};
            {parallel_interrupt, second_parallel_interrupt} = {~k[0], 1'b0};
            extra_address_decode = k[0];
            far_lvl[2] = ~k[0];
            wreg(focr_pkg::IDX_FLOPPY_OPT, v);
            @(negedge clk_sys);
            chk("shared", v[7] ? {3'h0, 1'b1, v[2] ? 1'b0 : k[0], 3'h0} : 8'h00,
                {3'h0, pin_oe[2], pin_oe[2] & pin_o[2], 3'h0});
            chk("shared_b", v[2] ? 8'h00 : {6'h0, 1'b1, ~k[0]},
                {6'h0, pin_oe[3], pin_o[3]});
            chk("drive_two_indicator", {7'h0, !v[7] & ~k[0]}, {7'h0, drive_two_indicator});
        end
        // extended setup, hardware reset, refused access, lock
        wreg(focr_pkg::IDX_EXT_SETUP, 8'h5a);
        hw_reset = 1'b1;
        rreg(focr_pkg::IDX_EXT_SETUP, 8'h5a);
        hw_reset = 1'b0;
        cfg_mode = 1'b0;
        wreg(focr_pkg::IDX_EXT_SETUP, 8'h11);
        cfg_mode = 1'b1;
        chk("ext_setup", 8'h5a, ext_setup);
        wreg(focr_pkg::IDX_LOCK, 8'h00);
        wreg(focr_pkg::IDX_EXT_SETUP, 8'h11);
        chk("ext_setup", 8'h5a, ext_setup);
        rreg(focr_pkg::IDX_FLOPPY_OPT, 8'h00);
        @(negedge clk_sys);
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        rreg(focr_pkg::IDX_FLOPPY_OPT, 8'h78);
        wreg(focr_pkg::IDX_EXT_SETUP, 8'h22);
        rreg(focr_pkg::IDX_EXT_SETUP, 8'h22);
        // index port reads back the index in force
        @(negedge clk_sys);
        cfg_port_data = 1'b0;
        cfg_rd = 1'b1;
        @(negedge clk_sys);
        cfg_rd = 1'b0;
        @(negedge clk_sys);
        chk("cfg_index", focr_pkg::IDX_EXT_SETUP, cfg_rdata);
        end_of_test();
    end
endmodule

`default_nettype wire
